// ==== core/swf_pkg.sv ====
// Shared constants and types for the supervisor watchdog with fail-over flag
package swf_pkg;

	// ----------------------------------------------------------------
	// Variant selection
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SWF_VAR_TIMEOUT = 2'b00,
		SWF_VAR_WINDOW = 2'b01,
		SWF_VAR_GATED = 2'b10
	} swf_variant_t;

	typedef enum logic [0:0] {
		SWF_OPEN_50 = 1'b0,
		SWF_OPEN_75 = 1'b1
	} swf_window_t;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SWF_CLK_MHZ = 200;
	localparam int SWF_WD_PERIOD_US = 10000;
	localparam int SWF_RST_PERIOD_US = 2000;
	localparam int SWF_WD_CYCLES = SWF_WD_PERIOD_US * SWF_CLK_MHZ;
	localparam int SWF_RST_CYCLES = SWF_RST_PERIOD_US * SWF_CLK_MHZ;
	localparam int SWF_INIT_FACTOR = 8;
	localparam int SWF_FAULT_COUNT = 3;
	localparam int SWF_GOOD_COUNT = 3;
	localparam int SWF_CNT_W = 32;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic SWF_RESET_N_INIT = 1'b0;
	localparam logic SWF_FAIL_N_INIT = 1'b1;
	localparam logic [2:0] SWF_SYNC_INIT = 3'h7;

endpackage : swf_pkg

// ==== core/swf_sync.sv ====
// Three-stage input synchroniser with agreement filter and falling-edge pulse
`timescale 1ns/1ps
module swf_sync
	import swf_pkg::*;
(
	input wire logic CLK_I, // Block clock
	input wire logic RST_B_I, // Sync reset, active low
	input wire logic async_i, // Pin from outside the domain
	output logic level_o, // Filtered level
	output logic fall_o // One-cycle pulse on a filtered fall
);
	logic [2:0] sync_reg;
	logic level_reg;

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			sync_reg <= SWF_SYNC_INIT;
		end else begin
			sync_reg <= {sync_reg[1:0], async_i};
		end
	end

	// Stage 0 is read only by stage 1; the filter looks at stages 1 and 2
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			level_reg <= 1'b1;
		end else if (sync_reg[1] == sync_reg[2]) begin
			level_reg <= sync_reg[2];
		end
	end

	assign level_o = level_reg;
	assign fall_o = level_reg && (sync_reg[1] == sync_reg[2]) && !sync_reg[2];

endmodule // swf_sync

// ==== core/swf_timer.sv ====
// Clearable up-counting period timer that saturates at all ones
`timescale 1ns/1ps
module swf_timer
	import swf_pkg::*;
#(
	parameter int W = SWF_CNT_W
) (
	input wire logic CLK_I, // Block clock
	input wire logic RST_B_I, // Sync reset, active low
	input wire logic clear_i, // Restart from zero
	input wire logic run_i, // Count enable
	output logic [W-1:0] count_o // Cycles since clear
);
	logic [W-1:0] count_reg;

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I || clear_i) begin
			count_reg <= '0;
		end else if (run_i && count_reg != '1) begin
			count_reg <= count_reg + W'(1);
		end
	end

	assign count_o = count_reg;

endmodule // swf_timer

// ==== core/swf_supervisor.sv ====
// Supervisor: power-on reset, watchdog (timeout, window, gated) and fail-over flag
//
// Functional notes
// - Timeout and window variants: reset low while level is low; release a full reset period after recovery.
// - Timeout variant: missed kick within watchdog period gives one reset period.
// - Watchdog counter clears on reset release and on every accepted kick fall.
// - Counter held at zero during reset; counts from zero after release.
// - Kick falls during reset are ignored entirely.
// - Timeout and window variants: no kick within watchdog period gives reset low at once for reset period.
// - Window variant: closed then open window; open-window kick is good.
// - Window variant: closed-window kick is an early fault giving reset.
// - Open window is a build option of 50 or 75 percent.
// - Kicks right at the window boundary may be judged either way.
// - Timeout variants: flag low after three expired periods with no kick.
// - Timeout variants: flag stays low until three timely kicks in a row.
// - Window variant: flag low after three bad events, high after three good.
// - Flag never asserted while the monitored or gating level is low.
// - Gated variant: watchdog stopped while gating level is low.
// - Gated variant: first period after gating rise is eight times normal.
// - Kick during extended period reverts to the normal period at once.
// - Extended period expiry drops the flag and itself restores normal period.
// - Timeout and window variants: at power-up reset stays low until level rises plus one reset period.
// - Disable setting turns off all watchdog faults and holds the flag high.
`timescale 1ns/1ps
module swf_supervisor
	import swf_pkg::*;
#(
	parameter swf_variant_t VARIANT = SWF_VAR_TIMEOUT,
	parameter swf_window_t OPEN_SIZE = SWF_OPEN_50,
	parameter int WD_CYCLES = SWF_WD_CYCLES,
	parameter int RST_CYCLES = SWF_RST_CYCLES
) (
	input wire logic CLK_I, // 200 MHz block clock
	input wire logic RST_B_I, // Sync reset, active low
	input wire logic KICK_IN_I, // Watchdog kick pin, falling edge counts
	input wire logic MONITOR_LEVEL_OK_I, // Monitored or gating level above threshold
	input wire logic WD_DISABLE_I, // Watchdog period setting selects disabled
	output logic RESET_N_O, // Reset output, active low
	output logic FAIL_N_O // Fail-over flag, active low
);
	import swf_pkg::*;

	// ----------------------------------------------------------------
	// Derived counts
	// ----------------------------------------------------------------
	localparam logic [SWF_CNT_W-1:0] WD_LEN = SWF_CNT_W'(WD_CYCLES);
	localparam logic [SWF_CNT_W-1:0] WD_INIT_LEN = SWF_CNT_W'(WD_CYCLES * SWF_INIT_FACTOR);
	localparam logic [SWF_CNT_W-1:0] RST_LEN = SWF_CNT_W'(RST_CYCLES);
	// Open window is OPEN_SIZE of the period, so closed window is the rest
	localparam logic [SWF_CNT_W-1:0] CLOSED_LEN = (OPEN_SIZE == SWF_OPEN_75) ?
		SWF_CNT_W'(WD_CYCLES / 4) : SWF_CNT_W'(WD_CYCLES / 2);
	localparam logic [1:0] FAULT_N = 2'(SWF_FAULT_COUNT);
	localparam logic [1:0] GOOD_N = 2'(SWF_GOOD_COUNT);

	// ----------------------------------------------------------------
	// Inputs
	// ----------------------------------------------------------------
	logic kick_level;
	logic kick_fall;
	logic lvl_ok;
	logic lvl_fall_unused;
	logic wd_off;
	logic dis_sync_reg;
	logic [2:0] dis_pipe_reg;

	swf_sync u_kick_sync (
		.CLK_I(CLK_I),
		.RST_B_I(RST_B_I),
		.async_i(KICK_IN_I),
		.level_o(kick_level),
		.fall_o(kick_fall)
	);

	swf_sync u_level_sync (
		.CLK_I(CLK_I),
		.RST_B_I(RST_B_I),
		.async_i(MONITOR_LEVEL_OK_I),
		.level_o(lvl_ok),
		.fall_o(lvl_fall_unused)
	);

	// Disable strap is static; three stages with agreement like any pin
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			dis_pipe_reg <= 3'h0;
		end else begin
			dis_pipe_reg <= {dis_pipe_reg[1:0], WD_DISABLE_I};
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			dis_sync_reg <= 1'b0;
		end else if (dis_pipe_reg[1] == dis_pipe_reg[2]) begin
			dis_sync_reg <= dis_pipe_reg[2];
		end
	end

	assign wd_off = dis_sync_reg;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic reset_n_reg;
	logic fail_n_reg;
	logic rst_run_reg;
	logic [SWF_CNT_W-1:0] rst_cnt_reg;
	logic extended_reg;
	logic lvl_ok_d_reg;
	logic [1:0] bad_cnt_reg;
	logic [1:0] good_cnt_reg;
	logic [SWF_CNT_W-1:0] wd_cnt;
	logic wd_clear;
	logic wd_run;
	logic wd_active;
	logic kick_ok;
	logic [SWF_CNT_W-1:0] wd_limit;
	logic late_fault;
	logic early_fault;
	logic good_kick;
	logic fault_rst;
	logic reset_rise;

	// Gated variant holds the reset output high; its watchdog runs only on the level
	assign wd_active = !wd_off && ((VARIANT == SWF_VAR_GATED) ? lvl_ok : reset_n_reg);
	assign kick_ok = kick_fall && wd_active;
	assign wd_limit = extended_reg ? WD_INIT_LEN : WD_LEN;
	assign late_fault = wd_active && (wd_cnt >= wd_limit - SWF_CNT_W'(1)) && !kick_ok;
	// Boundary kick lands on the compare edge; either side is acceptable
	assign early_fault = (VARIANT == SWF_VAR_WINDOW) && kick_ok && (wd_cnt < CLOSED_LEN);
	assign good_kick = kick_ok && !early_fault;
	assign fault_rst = (VARIANT != SWF_VAR_GATED) && (late_fault || early_fault);
	assign reset_rise = rst_run_reg && (rst_cnt_reg >= RST_LEN - SWF_CNT_W'(1)) && lvl_ok;
	// Late fault in gated variant restarts period; rising level restarts too
	assign wd_clear = reset_rise || kick_ok || !wd_active || late_fault || (lvl_ok && !lvl_ok_d_reg);
	assign wd_run = wd_active;

	swf_timer #(
		.W(SWF_CNT_W)
	) u_wd_timer (
		.CLK_I(CLK_I),
		.RST_B_I(RST_B_I),
		.clear_i(wd_clear),
		.run_i(wd_run),
		.count_o(wd_cnt)
	);

	// ----------------------------------------------------------------
	// Reset output and reset period
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			reset_n_reg <= SWF_RESET_N_INIT;
			rst_run_reg <= 1'b0;
			rst_cnt_reg <= '0;
		end else if (VARIANT == SWF_VAR_GATED) begin
			reset_n_reg <= 1'b1;
			rst_run_reg <= 1'b0;
			rst_cnt_reg <= '0;
		end else if (!lvl_ok) begin
			reset_n_reg <= 1'b0;
			rst_run_reg <= 1'b0;
			rst_cnt_reg <= '0;
		end else if (fault_rst) begin
			reset_n_reg <= 1'b0;
			rst_run_reg <= 1'b1;
			rst_cnt_reg <= '0;
		end else if (!reset_n_reg) begin
			if (reset_rise) begin
				reset_n_reg <= 1'b1;
				rst_run_reg <= 1'b0;
			end else begin
				rst_run_reg <= 1'b1;
				rst_cnt_reg <= rst_run_reg ? rst_cnt_reg + SWF_CNT_W'(1) : '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Extended first period (gated variant)
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			lvl_ok_d_reg <= 1'b0;
			extended_reg <= 1'b0;
		end else begin
			lvl_ok_d_reg <= lvl_ok;
			if (VARIANT != SWF_VAR_GATED) begin
				extended_reg <= 1'b0;
			end else if (lvl_ok && !lvl_ok_d_reg) begin
				extended_reg <= 1'b1;
			end else if (kick_ok || late_fault) begin
				extended_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Fail-over flag
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			fail_n_reg <= SWF_FAIL_N_INIT;
			bad_cnt_reg <= 2'h0;
			good_cnt_reg <= 2'h0;
		end else if (!lvl_ok || wd_off) begin
			fail_n_reg <= 1'b1;
			bad_cnt_reg <= 2'h0;
			good_cnt_reg <= 2'h0;
		end else if (late_fault || early_fault) begin
			good_cnt_reg <= 2'h0;
			if (extended_reg || bad_cnt_reg == FAULT_N - 2'h1) begin
				fail_n_reg <= 1'b0;
				bad_cnt_reg <= FAULT_N - 2'h1;
			end else begin
				bad_cnt_reg <= bad_cnt_reg + 2'h1;
			end
		end else if (good_kick) begin
			bad_cnt_reg <= 2'h0;
			if (!fail_n_reg) begin
				if (good_cnt_reg == GOOD_N - 2'h1) begin
					fail_n_reg <= 1'b1;
					good_cnt_reg <= 2'h0;
				end else begin
					good_cnt_reg <= good_cnt_reg + 2'h1;
				end
			end
		end
	end

	assign RESET_N_O = reset_n_reg;
	assign FAIL_N_O = fail_n_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_level_low_reset: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		(VARIANT != SWF_VAR_GATED && !lvl_ok) |=> !RESET_N_O)
		else $error("reset high while level low");

	chk_flag_level_low: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		!lvl_ok |=> FAIL_N_O)
		else $error("fail flag asserted with level low");

	chk_counter_held: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		(VARIANT != SWF_VAR_GATED && !reset_n_reg && $past(!reset_n_reg)) |-> wd_cnt == '0)
		else $error("watchdog counter moved during reset");

	chk_kick_clears: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		kick_ok |=> wd_cnt == '0)
		else $error("accepted kick did not clear counter");

	chk_late_resets: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		(VARIANT != SWF_VAR_GATED && late_fault && lvl_ok) |=> !RESET_N_O)
		else $error("late fault did not assert reset");

	chk_early_resets: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		(early_fault && lvl_ok) |=> !RESET_N_O)
		else $error("early fault did not assert reset");

	chk_reset_ignore: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		(VARIANT != SWF_VAR_GATED && !reset_n_reg) |-> !kick_ok)
		else $error("kick accepted during reset");

	chk_disable_quiet: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		wd_off |-> !late_fault && !early_fault && !kick_ok)
		else $error("watchdog active while disabled");

	chk_extend_set: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		(VARIANT == SWF_VAR_GATED && lvl_ok && !lvl_ok_d_reg) |=> extended_reg)
		else $error("extended period not armed");

	chk_extend_kick: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		(extended_reg && kick_ok && !(lvl_ok && !lvl_ok_d_reg)) |=> !extended_reg)
		else $error("kick did not end extended period");

endmodule // swf_supervisor

// ==== dv/swf_kick_model.sv ====
// Behavioural model of the supervised controller that issues watchdog kicks
`timescale 1ns/1ps
module swf_kick_model (
	input wire logic clk_i, // Block clock
	input wire logic run_i, // Keep kicking while high
	input wire logic [7:0] gap_i, // Cycles between kick falls, minus one
	output logic kick_o = 1'b1 // Kick pin, idles high
);
	logic [7:0] cnt_reg = 8'h00;

	// ----------------------------------------------------------------
	// Kick pacing
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (!run_i || cnt_reg == gap_i) begin
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	// Low for six cycles so the pin filter sees a solid level, well inside the period
	always @(posedge clk_i) begin
		kick_o <= !(run_i && cnt_reg >= gap_i - 8'h05);
	end
endmodule // swf_kick_model

// ==== dv/tb_top.sv ====
// Self-checking bench for the supervisor in its timeout and window variants
`timescale 1ns/1ps
module tb_top;
	import swf_pkg::*;
	localparam int WD = 64;
	localparam int RS = 32;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic level_ok = 1'b0;
	logic wd_dis = 1'b0;
	logic run = 1'b0;
	logic kick;
	logic reset_n;
	logic fail_n;
	logic run2 = 1'b0;
	logic kick2;
	logic reset2_n;
	logic fail2_n;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	int n;
	int bad;

	always #2.5 clk = ~clk;

	swf_kick_model swf_kick_model_inst (.clk_i(clk), .run_i(run), .gap_i(8'h28), .kick_o(kick));

	swf_supervisor #(.VARIANT(SWF_VAR_TIMEOUT), .OPEN_SIZE(SWF_OPEN_50), .WD_CYCLES(WD),
		.RST_CYCLES(RS)) swf_supervisor_inst (
		.CLK_I(clk),
		.RST_B_I(rst_b),
		.KICK_IN_I(kick),
		.MONITOR_LEVEL_OK_I(level_ok),
		.WD_DISABLE_I(wd_dis),
		.RESET_N_O(reset_n),
		.FAIL_N_O(fail_n)
	);

	// Window variant; kicks every 21 cycles fall inside its 32-cycle closed window
	swf_kick_model swf_kick_model_win_inst (.clk_i(clk), .run_i(run2), .gap_i(8'h14),
		.kick_o(kick2));

	swf_supervisor #(.VARIANT(SWF_VAR_WINDOW), .OPEN_SIZE(SWF_OPEN_50), .WD_CYCLES(WD),
		.RST_CYCLES(RS)) swf_supervisor_win_inst (
		.CLK_I(clk),
		.RST_B_I(rst_b),
		.KICK_IN_I(kick2),
		.MONITOR_LEVEL_OK_I(level_ok),
		.WD_DISABLE_I(wd_dis),
		.RESET_N_O(reset2_n),
		.FAIL_N_O(fail2_n)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic check_span(input int v, input int lo, input int hi);
		check(32'(v >= lo && v <= hi), 32'h1);
	endtask

	// Sample one time step after the edge so its updates have landed
	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	task automatic wait_rst(input logic v, input int lim, output int cnt);
		cnt = 0;
		while (reset_n !== v && cnt < lim) begin
			tick();
			cnt++;
		end
	endtask

	task automatic complete_run();
		if (err_total == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_power_up();
		repeat (40) tick();
		check(reset_n, 1'b0);
		@(posedge clk) level_ok <= 1'b1;
		wait_rst(1'b1, 200, n);
		check_span(n, RS, RS + 6);
	endtask

	task automatic test_good_kicks();
		@(posedge clk) run <= 1'b1;
		bad = 0;
		repeat (300) begin
			tick();
			if (reset_n !== 1'b1 || fail_n !== 1'b1) bad++;
		end
		check(bad, 0);
	endtask

	// Three missed periods in a row; each one resets, the third drops the flag
	task automatic test_late_faults();
		@(posedge clk) run <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			check(fail_n, 1'b1);
			wait_rst(1'b0, 200, n);
			if (i > 0) check_span(n, WD - 1, WD + 2);
			wait_rst(1'b1, 200, n);
			check_span(n, RS - 3, RS + 2);
		end
		check(fail_n, 1'b0);
	endtask

	task automatic test_recover();
		@(posedge clk) run <= 1'b1;
		repeat (100) tick();
		check(fail_n, 1'b0);
		repeat (40) tick();
		check(fail_n, 1'b1);
		check(reset_n, 1'b1);
	endtask

	task automatic test_level_drop();
		@(posedge clk) level_ok <= 1'b0;
		repeat (5) tick();
		check(reset_n, 1'b0);
		@(posedge clk) run <= 1'b0;
		repeat (300) tick();
		check(fail_n, 1'b1);
		check(reset_n, 1'b0);
		@(posedge clk) level_ok <= 1'b1;
		wait_rst(1'b1, 200, n);
		check_span(n, RS, RS + 6);
	endtask

	// Early kick in the closed window must pull reset low at once
	task automatic test_window_early();
		check(reset2_n, 1'b1);
		@(posedge clk) run2 <= 1'b1;
		n = 0;
		while (reset2_n !== 1'b0 && n < 100) begin
			tick();
			n++;
		end
		check_span(n, 15, 28);
		@(posedge clk) run2 <= 1'b0;
	endtask

	// No kicks at all: a disabled watchdog must neither reset nor flag
	task automatic test_disabled();
		@(posedge clk) wd_dis <= 1'b1;
		bad = 0;
		repeat (300) begin
			tick();
			if (reset_n !== 1'b1 || fail_n !== 1'b1) bad++;
		end
		check(bad, 0);
	endtask

	// ----------------------------------------------------------------
	// Sequence and hang guard
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			complete_run();
		end
	end

	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		test_power_up();
		test_good_kicks();
		test_late_faults();
		test_recover();
		test_level_drop();
		test_window_early();
		test_disabled();
		complete_run();
	end
endmodule // tb_top
